// [hdl/clpw_top.sv]
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RQ1: Duty rises linearly with the control level.
// RQ2: Levels outside the span saturate the duty.
// RQ3: Duty tracks the linear law within tolerance.
// RQ4: Unclamped variant rests low or high at extremes.
// RQ5: Two-sided clamp keeps 5-95 % and always toggles; at ratio 1 the output stays constant.
// RQ6: One-sided variants clamp ceiling or floor.
// RQ7: Invert bit flips the output after clamping.
// RQ8: Code top bit selects the inverted output.
// RQ9: New code waits sixteen times difference plus six.
// RQ10: Code accepted only when stable, no intermediates.
// RQ11: Ratio changes only at a period boundary.
// RQ12: Output held low during the start-up interval.
// RQ13: Start-up lasts 500 master ticks.
// RQ14: First pulse after start-up is whole.
// RQ15: Valid code must be resolved before output starts.
// RQ16: Ratios 1 to 16384 mirrored around the midpoint.
// RQ17: Duty level is an unsigned digital command.
// RQ18: Period is ratio ticks, high time counted.
module clpw_top #(
  parameter int CLAMP_MODE = 0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Master oscillator tick, one cycle wide
  input wire logic tick_i,
  // Divider and polarity selection code
  input wire logic [3:0] divider_polarity_code_i,
  // Register bus
  input wire clpw_pkg::clpw_axil_req_t axil_req_i,
  output wire clpw_pkg::clpw_axil_rsp_t axil_rsp_o,
  // Modulated output and applied polarity
  output logic pwm_o,
  output logic output_invert_o
);

  localparam logic [1:0] MODE = CLAMP_MODE[1:0];

  if (CLAMP_MODE < 0 || CLAMP_MODE > 3) begin : g_bad_mode
    $error("CLAMP_MODE must be 0 to 3");
  end

  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [10:0] duty_control_level_reg;
  logic wr_fire;
  logic [31:0] rd_word;
  logic rd_ok;

  logic [3:0] flt_code;
  logic flt_valid;
  logic [9:0] start_cnt_reg;
  logic started_reg;
  logic [3:0] act_code_reg;
  logic [14:0] per_cnt_reg;
  logic [14:0] high_act_reg;
  logic pwm_reg;
  logic output_invert_reg;
  logic [14:0] ratio_act;
  logic [14:0] ratio_new;
  logic [10:0] duty_lin;
  logic [10:0] duty_clamped;
  logic [25:0] prod;
  logic [14:0] high_new;
  logic period_end;

  clpw_code_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_i),
    .code_i(divider_polarity_code_i),
    .code_o(flt_code),
    .valid_o(flt_valid)
  );

  // Write channel: address and data are taken in either order, the response follows both.
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awready_reg <= 1'b1;
      awaddr_reg <= 12'h000;
    end else if (axil_req_i.awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      awaddr_reg <= axil_req_i.awaddr;
    end else if (bvalid_reg && axil_req_i.bready) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wready_reg <= 1'b1;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (axil_req_i.wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      wdata_reg <= axil_req_i.wdata;
      wstrb_reg <= axil_req_i.wstrb;
    end else if (bvalid_reg && axil_req_i.bready) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= clpw_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (awaddr_reg[11:2] == clpw_pkg::ADDR_CTRL[11:2]) ? clpw_pkg::RESP_OKAY : clpw_pkg::RESP_SLVERR;
    end else if (bvalid_reg && axil_req_i.bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // The level register honours byte lanes; status is read-only and refuses writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_control_level_reg <= clpw_pkg::CTRL_LEVEL_RST;
    end else if (wr_fire && awaddr_reg[11:2] == clpw_pkg::ADDR_CTRL[11:2]) begin
      if (wstrb_reg[0]) begin
        duty_control_level_reg[7:0] <= wdata_reg[7:0]; // [RQ17]
      end
      if (wstrb_reg[1]) begin
        duty_control_level_reg[10:8] <= wdata_reg[10:8];
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (axil_req_i.araddr[11:2] == clpw_pkg::ADDR_CTRL[11:2]) begin
      rd_word[10:0] = duty_control_level_reg;
    end else if (axil_req_i.araddr[11:2] == clpw_pkg::ADDR_STAT[11:2]) begin
      rd_word[clpw_pkg::STAT_CODE_LSB +: 4] = act_code_reg;
      rd_word[clpw_pkg::STAT_STARTED_BIT] = started_reg;
      rd_word[clpw_pkg::STAT_OUT_BIT] = pwm_reg;
      rd_word[clpw_pkg::STAT_PEND_BIT] = flt_valid && (flt_code != act_code_reg);
      rd_word[clpw_pkg::STAT_VALID_BIT] = flt_valid;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= clpw_pkg::RESP_OKAY;
    end else if (axil_req_i.arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_ok ? clpw_pkg::RESP_OKAY : clpw_pkg::RESP_SLVERR;
    end else if (rvalid_reg && axil_req_i.rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign axil_rsp_o = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg, bresp: bresp_reg,
                        arready: arready_reg, rvalid: rvalid_reg, rdata: rdata_reg, rresp: rresp_reg};

  // Duty computation for the code that will run next.
  assign ratio_act = clpw_pkg::clpw_ratio_of(act_code_reg); // [RQ16]
  assign ratio_new = clpw_pkg::clpw_ratio_of(flt_code); // [RQ16]

  always_comb begin
    // Level minus 10 %, over the 80 % span, saturating at both ends.
    if (duty_control_level_reg <= clpw_pkg::LEVEL_LO) begin
      duty_lin = 11'h000; // [RQ2]
    end else if (duty_control_level_reg - clpw_pkg::LEVEL_LO >= clpw_pkg::DUTY_FULL) begin
      duty_lin = clpw_pkg::DUTY_FULL; // [RQ2]
    end else begin
      duty_lin = duty_control_level_reg - clpw_pkg::LEVEL_LO; // [RQ1] [RQ3]
    end
    duty_clamped = duty_lin;
    if ((MODE == clpw_pkg::CLAMP_BOTH || MODE == clpw_pkg::CLAMP_FLOOR) && duty_lin < clpw_pkg::DUTY_5PCT) begin
      duty_clamped = clpw_pkg::DUTY_5PCT; // [RQ5] [RQ6]
    end
    if ((MODE == clpw_pkg::CLAMP_BOTH || MODE == clpw_pkg::CLAMP_CEIL) && duty_lin > clpw_pkg::DUTY_95PCT) begin
      duty_clamped = clpw_pkg::DUTY_95PCT; // [RQ5] [RQ6]
    end
    prod = 26'(duty_clamped) * 26'(ratio_new);
    high_new = prod[24:10]; // [RQ18]
    // Short periods round the clamped floor down to 0; above ratio 1, keep one tick of each phase so it still toggles.
    if (ratio_new > 15'h0001) begin
      if ((MODE == clpw_pkg::CLAMP_BOTH || MODE == clpw_pkg::CLAMP_FLOOR) && high_new == 15'h0000) begin
        high_new = 15'h0001; // [RQ5]
      end
      if ((MODE == clpw_pkg::CLAMP_BOTH || MODE == clpw_pkg::CLAMP_CEIL) && high_new == ratio_new) begin
        high_new = ratio_new - 15'h0001; // [RQ5]
      end
    end
  end

  // Start-up interval counts master ticks, then waits for a resolved code.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_cnt_reg <= 10'h000;
      started_reg <= 1'b0;
    end else if (!started_reg) begin
      if (tick_i && start_cnt_reg < clpw_pkg::START_TICKS) begin
        start_cnt_reg <= start_cnt_reg + 10'h001; // [RQ13]
      end
      if (start_cnt_reg == clpw_pkg::START_TICKS && flt_valid) begin
        started_reg <= 1'b1; // [RQ15]
      end
    end
  end

  assign period_end = tick_i && (per_cnt_reg == ratio_act - 15'h0001);

  // Code and high time are latched only at a period start, so no pulse is cut short.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_code_reg <= 4'h0;
      per_cnt_reg <= 15'h0000;
      high_act_reg <= 15'h0000;
    end else if (!started_reg) begin
      act_code_reg <= flt_code; // [RQ14]
      per_cnt_reg <= 15'h0000;
      high_act_reg <= high_new;
    end else if (period_end) begin
      act_code_reg <= flt_code; // [RQ11]
      per_cnt_reg <= 15'h0000;
      high_act_reg <= high_new; // [RQ18]
    end else if (tick_i) begin
      per_cnt_reg <= per_cnt_reg + 15'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_reg <= 1'b0;
      output_invert_reg <= 1'b0;
    end else begin
      pwm_reg <= started_reg && ((per_cnt_reg < high_act_reg) ^ act_code_reg[3]); // [RQ7] [RQ8] [RQ12] [RQ4]
      output_invert_reg <= act_code_reg[3]; // [RQ8]
    end
  end

  assign pwm_o = pwm_reg;
  assign output_invert_o = output_invert_reg;

  a_startup_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ12]
    $rose(pwm_reg) |-> $past(started_reg))
    else $error("output rose before start-up ended");

  a_startup_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
    $rose(started_reg) |-> (start_cnt_reg == clpw_pkg::START_TICKS))
    else $error("start-up ended before 500 ticks");

  a_startup_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ15]
    $rose(started_reg) |-> $past(flt_valid))
    else $error("start-up ended without a resolved code");

  a_ratio_boundary: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
    (started_reg && $past(started_reg) && act_code_reg != $past(act_code_reg)) |-> $past(period_end))
    else $error("code applied inside a period");

  a_invert_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    (started_reg && $past(started_reg) && $past(per_cnt_reg) >= $past(high_act_reg))
      |-> (pwm_reg == $past(act_code_reg[3])))
    else $error("low phase does not follow the code polarity");

  a_two_sided: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    (MODE == clpw_pkg::CLAMP_BOTH && started_reg && ratio_act > 15'h0001)
      |-> (high_act_reg != 15'h0000 && high_act_reg < ratio_act))
    else $error("two-sided clamp let the output stop");

  a_zero_duty: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    (MODE == clpw_pkg::CLAMP_NONE && duty_control_level_reg <= clpw_pkg::LEVEL_LO) |-> (high_new == 15'h0000))
    else $error("unclamped variant not at zero duty");

  a_saturate: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    (duty_control_level_reg >= clpw_pkg::LEVEL_LO + clpw_pkg::DUTY_FULL) |-> (duty_lin == clpw_pkg::DUTY_FULL))
    else $error("duty not saturated above the span");

  a_period_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ18]
    started_reg |-> (per_cnt_reg < ratio_act))
    else $error("period counter beyond the ratio");

  a_ceil_clamp: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (MODE == clpw_pkg::CLAMP_CEIL) |-> (duty_clamped <= clpw_pkg::DUTY_95PCT))
    else $error("ceiling clamp exceeded");

endmodule : clpw_top
`default_nettype wire

// [hdl/clpw_pkg.sv]
`default_nettype none
package clpw_pkg;

  // Widths of the duty level, the selection code and the period counter.
  localparam int LEVEL_W = 11;
  localparam int CODE_W = 4;
  localparam int RATIO_W = 15;
  localparam int PROD_W = 26;

  // One level count is 1/1280 of the reference, so the 10 % to 90 % span is exactly 1024 counts.
  localparam logic [10:0] LEVEL_LO = 11'h080;
  localparam logic [10:0] DUTY_FULL = 11'h400;
  localparam int DUTY_SHIFT = 10;
  localparam logic [10:0] DUTY_5PCT = 11'h033;
  localparam logic [10:0] DUTY_95PCT = 11'h3CD;

  // Timing counts in master ticks.
  localparam logic [9:0] START_TICKS = 10'h1F4;
  localparam logic [4:0] FLT_BASE = 5'h06;
  localparam int FLT_UNIT_SHIFT = 4;
  localparam int FLT_CNT_W = 9;

  // Clamp variants.
  localparam logic [1:0] CLAMP_NONE = 2'h0;
  localparam logic [1:0] CLAMP_BOTH = 2'h1;
  localparam logic [1:0] CLAMP_CEIL = 2'h2;
  localparam logic [1:0] CLAMP_FLOOR = 2'h3;

  // Register map and field positions.
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [10:0] CTRL_LEVEL_RST = 11'h000;
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_STARTED_BIT = 4;
  localparam int STAT_OUT_BIT = 5;
  localparam int STAT_PEND_BIT = 6;
  localparam int STAT_VALID_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } clpw_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } clpw_axil_rsp_t;

  // Codes 0..7 give 4**code, codes 8..15 mirror them.
  function automatic logic [14:0] clpw_ratio_of(input logic [3:0] code);
    logic [2:0] idx;
    idx = code[3] ? ~code[2:0] : code[2:0];
    return 15'h0001 << {idx, 1'b0};
  endfunction : clpw_ratio_of

endpackage : clpw_pkg
`default_nettype wire

// [hdl/clpw_code_filter.sv]
`timescale 1ns/10ps
`default_nettype none
module clpw_code_filter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Master tick and raw code
  input wire logic tick_i,
  input wire logic [3:0] code_i,
  // Accepted code
  output logic [3:0] code_o,
  output logic valid_o
);

  logic [3:0] cand_reg;
  logic [3:0] code_reg;
  logic valid_reg;
  logic [8:0] cnt_reg;
  logic [3:0] diff;
  logic [8:0] need;

  // Before the first code is accepted the difference counts as zero.
  always_comb begin
    diff = 4'h0;
    if (valid_reg) begin
      diff = (cand_reg > code_reg) ? cand_reg - code_reg : code_reg - cand_reg;
    end
    need = {({1'b0, diff} + clpw_pkg::FLT_BASE), 4'h0};
  end

  // A candidate restarts the wait whenever the sample moves, so a wandering input is never taken.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cand_reg <= 4'h0;
      code_reg <= 4'h0;
      valid_reg <= 1'b0;
      cnt_reg <= 9'h000;
    end else if (tick_i) begin
      if (code_i != cand_reg) begin
        cand_reg <= code_i;
        cnt_reg <= 9'h000;
      end else if (!valid_reg || (cand_reg != code_reg)) begin
        if (cnt_reg + 9'h001 == need) begin // [RQ9]
          code_reg <= cand_reg; // [RQ10]
          valid_reg <= 1'b1;
          cnt_reg <= 9'h000;
        end else begin
          cnt_reg <= cnt_reg + 9'h001;
        end
      end else begin
        cnt_reg <= 9'h000;
      end
    end
  end

  assign code_o = code_reg;
  assign valid_o = valid_reg;

  a_filter_delay: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ9]
    (valid_reg && $past(valid_reg) && code_reg != $past(code_reg)) |-> ($past(cnt_reg) + 9'h001 == $past(need)))
    else $error("code accepted after the wrong delay");

  a_no_steps: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
    (valid_reg && code_reg != $past(code_reg)) |-> (code_reg == $past(cand_reg) && $past(code_i) == $past(cand_reg)))
    else $error("code accepted that was not the stable candidate");

endmodule : clpw_code_filter
`default_nettype wire

// [dv/clpw_src_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Stands in for the master oscillator and the selection divider.
// In slow mode the tick comes every other clock, as a slower master oscillator would.
module clpw_src_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench controls
  input wire logic slow_i,
  input wire logic [3:0] code_req_i,
  // Far-side signals
  output logic tick_o,
  output logic [3:0] code_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'h1;
    end else begin
      tick_o <= !slow_i || !tick_o;
    end
  end

  // The code settles one clock after the bench asks for it, like a divider that needs time.
  always_ff @(posedge clk_i) begin
    code_o <= code_req_i;
  end
endmodule : clpw_src_model
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic slow = 1'h0;
  logic [3:0] code = 4'h2;
  logic tick;
  logic [3:0] code_w;
  logic pwm_o;
  logic inv_o;
  logic [3:1] pwm_c;
  logic [3:0] pw;
  int hi [4];
  clpw_pkg::clpw_axil_req_t req = '0;
  clpw_pkg::clpw_axil_rsp_t rsp;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h6BA3A461;
  logic [10:0] lv [8] = '{11'h000, 11'h07F, 11'h080, 11'h081, 11'h280, 11'h47F, 11'h480, 11'h7FF};

  always #50 clk_i = ~clk_i;

  clpw_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .code_req_i(code), .tick_o(tick),
    .code_o(code_w));
  clpw_top #(.CLAMP_MODE(0)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
    .divider_polarity_code_i(code_w), .axil_req_i(req), .axil_rsp_o(rsp), .pwm_o(pwm_o),
    .output_invert_o(inv_o));

  // The three clamp variants run beside the unclamped one on the same bus and link.
  for (genvar m = 1; m < 4; m++) begin : g_clamp
    clpw_top #(.CLAMP_MODE(m)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
      .divider_polarity_code_i(code_w), .axil_req_i(req), .axil_rsp_o(), .pwm_o(pwm_c[m]),
      .output_invert_o());
  end

  assign pw = {pwm_c, pwm_o};

  task automatic wrap_up;
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %0t: value %h, expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %0t: response %h, expected %h", $time, g, e);
    end
  endtask : chk_rsp

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // High clocks in a 128-clock window, which spans whole periods for ratio 16 at either tick rate.
  // Above ratio 1, a clamped end keeps one tick of each phase so that the output never stops toggling.
  function automatic int exp_hi(input logic [10:0] l, input int ratio, input logic inv, input int mode);
    int d;
    int fl;
    int ce;
    fl = (mode == 1 || mode == 3) ? int'(clpw_pkg::DUTY_5PCT) : 0;
    ce = (mode == 1 || mode == 2) ? int'(clpw_pkg::DUTY_95PCT) : 1024;
    d = int'(l) - 128;
    if (d < fl) d = fl;
    if (d > ce) d = ce;
    d = (d * ratio) >> 10;
    if (ratio > 1 && fl > 0 && d < 1) d = 1;
    if (ratio > 1 && ce < 1024 && d > ratio - 1) d = ratio - 1;
    d = d * 128 / ratio;
    return inv ? 128 - d : d;
  endfunction : exp_hi

  // Bready and rready stay high throughout, so no strobe is ever dropped and raised in one step.
  task automatic bus_w(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    req.awaddr <= a;
    req.awvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
    end while (rsp.bvalid !== 1'h1);
    r = rsp.bresp;
  endtask : bus_w

  task automatic bus_r(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
    end while (rsp.rvalid !== 1'h1);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask : bus_r

  // An unknown level counts far out of range, so it can never pass as a low phase.
  task automatic measure;
    for (int m = 0; m < 4; m++) hi[m] = 0;
    repeat (128) begin
      @(posedge clk_i);
      for (int m = 0; m < 4; m++) begin
        if (pw[m] === 1'h1) hi[m]++;
        else if (pw[m] !== 1'h0) hi[m] += 1000;
      end
    end
  endtask : measure

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    int n;
    int c0;
    logic [10:0] l;
    logic [31:0] rd;
    logic [1:0] rr;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    c0 = cyc;
    chk(32'(pwm_o), 32'h0);
    chk(32'(inv_o), 32'h0);
    bus_r(clpw_pkg::ADDR_CTRL, rd, rr);
    chk(rd, 32'h0);
    bus_w(clpw_pkg::ADDR_CTRL, 32'hFFFFFA80, rr);
    chk_rsp(rr, clpw_pkg::RESP_OKAY);
    while (pwm_o !== 1'h1 && cyc - c0 < 700) @(posedge clk_i);
    chk(32'(cyc - c0 >= 500 && cyc - c0 <= 530), 32'h1);
    bus_r(clpw_pkg::ADDR_STAT, rd, rr);
    chk(rd & 32'h9F, 32'h92);
    bus_r(clpw_pkg::ADDR_CTRL, rd, rr);
    chk(rd, 32'h280);
    bus_r(12'h008, rd, rr);
    chk_rsp(rr, clpw_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    bus_w(clpw_pkg::ADDR_STAT, 32'hFFFFFFFF, rr);
    chk_rsp(rr, clpw_pkg::RESP_SLVERR);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 14; i++) begin
        l = (i < 8) ? lv[i] : seed[10:0];
        seed = xs(seed);
        bus_w(clpw_pkg::ADDR_CTRL, 32'(l), rr);
        repeat (80) @(posedge clk_i);
        measure();
        for (int m = 0; m < 4; m++) begin
          chk(32'(hi[m]), 32'(exp_hi(l, 16, k[0], m)));
        end
      end
      if (k == 0) begin
        code <= 4'hD;
        n = 0;
        while (inv_o !== 1'h1 && n < 400) begin
          @(posedge clk_i);
          n++;
        end
        chk(32'(n >= 270 && n <= 295), 32'h1);
        bus_r(clpw_pkg::ADDR_STAT, rd, rr);
        chk(rd & 32'hF, 32'hD);
        slow <= 1'h1;
      end
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
